// File: rtl/mbr_pkg.sv
/*
  Shared constants, types and the CRC step for the Modbus RTU request checker.
  Assumes byte-wide traffic from a UART layer running on the same clock.
*/
package mbr_pkg;

  // ----------------------------------------
  // Function, exception and error codes
  // ----------------------------------------
  localparam logic [7:0] FC_READ     = 8'h03;
  localparam logic [7:0] FC_WRITE1   = 8'h06;
  localparam logic [7:0] FC_DIAG     = 8'h08;
  localparam logic [7:0] FC_WRITEN   = 8'h10;
  localparam logic [7:0] EXC_FLAG    = 8'h80;
  localparam logic [7:0] EXC_NONE    = 8'h00;
  localparam logic [7:0] EXC_FUNC    = 8'h01;
  localparam logic [7:0] EXC_ADDR    = 8'h02;
  localparam logic [7:0] EXC_DATA    = 8'h03;
  localparam logic [7:0] EXC_BUSY    = 8'h04;
  localparam logic [7:0] ERR_NONE    = 8'h00;
  localparam logic [7:0] ERR_ADDR    = 8'h88;
  localparam logic [7:0] ERR_TOOL    = 8'h89;
  localparam logic [7:0] ERR_NVM     = 8'h8A;
  localparam logic [7:0] ERR_RANGE   = 8'h8C;
  localparam logic [7:0] ERR_DISABLE = 8'h8D;

  // ----------------------------------------
  // Limits and frame layout
  // ----------------------------------------
  localparam logic [15:0] ADDR_MAX   = 16'h1FFF;
  localparam logic [16:0] ADDR_END   = 17'h02000;
  localparam logic [15:0] CNT_LIMIT  = 16'h0011;
  localparam logic [7:0]  BCAST_ADDR = 8'h00;
  localparam logic [8:0]  MAX_FRAME  = 9'h100;
  localparam logic [8:0]  LEN_SAT    = 9'h101;
  localparam logic [8:0]  MIN_FRAME  = 9'h004;
  localparam logic [8:0]  FIXED_LEN  = 9'h008;
  localparam logic [8:0]  WM_HDR_LEN = 9'h009;
  localparam int          QUERY_MAX  = 41;
  localparam logic [5:0]  WM_DATA    = 6'h07;
  localparam logic [5:0]  EXC_LEN    = 6'h03;
  localparam logic [5:0]  ECHO_LEN   = 6'h06;
  localparam logic [5:0]  READ_HDR   = 6'h03;
  localparam logic [15:0] CRC_INIT   = 16'hFFFF;
  localparam logic [15:0] CRC_POLY   = 16'hA001;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    S_RX    = 4'h1,
    S_CHECK = 4'h2,
    S_ACC   = 4'h4,
    S_RESP  = 4'h8
  } mbr_state_t;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbr_reg_req_t;

  // One byte through the reflected CRC, LSB first
  function automatic logic [15:0] mbr_crc_byte(input logic [15:0] crc,
                                               input logic [7:0]  data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : mbr_crc_byte

endpackage : mbr_pkg

// File: rtl/mbr_fifo.sv
/*
  Byte FIFO between the response builder and the UART transmitter.
  Assumes both sides on mclk; the drain side may stall at will.
*/
`timescale 1ns/100ps
module mbr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             ce,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("mbr_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  wire              full  = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  wire              empty = (wrPtr == rdPtr);
  wire              push  = ce && inValid && !full;
  wire              pop   = ce && outReady && !empty;

  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

  a_no_overflow : assert property (@(posedge mclk) disable iff (!reset_n)
    full && !pop |=> wrPtr == $past(wrPtr))
    else $error("fifo written while full");

endmodule : mbr_fifo

// File: rtl/mbr_request_checker.sv
/*
  Modbus RTU slave request checker: gathers a query, checks it, reaches the
  parameter store and queues the normal or exception response.
  Assumes a UART layer on mclk that marks bytes, byte errors and frame ends,
  and a parameter store that acknowledges each register access.
*/
// Operation
// - Unknown function or diagnosis sub-function: exception 01h
// - Address beyond 1FFFh: exception 02h, error 88h
// - Address plus count reaching 2000h: exception 02h
// - Count zero or above 16: exception 03h
// - Byte count not twice register count: 03h
// - Query length wrong for function: exception 03h
// - Tool session active: exception 04h, error 89h
// - Memory busy or memory alarm: 04h, 8Ah
// - Write value out of range: 04h, 8Ch
// - Execution disabled on a write: exception 04h, error 8Dh
// - Read returns 16-bit registers, sixteen at most
// - Registers fetched in ascending address order
// - Read response echoes, byte count, high first
// - Exception: address, function plus 80h, code, CRC
// - CRC-16 from FFFFh, reflected A001h, bitwise
// - Drop framing, parity, CRC or overlong queries
// - Broadcast runs silently; foreign address ignored
`timescale 1ns/100ps
module mbr_request_checker
  import mbr_pkg::*;
#(
  parameter int MAX_REGS   = 16,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire logic [7:0]   slaveAddr,
  input  wire logic         rxValid,
  input  wire logic [7:0]   rxData,
  input  wire logic         rxErr,
  input  wire logic         rxEnd,
  input  wire logic         toolSession,
  input  wire logic         internal_processing_busy_flag,
  input  wire logic         nvmAlarm,
  input  wire logic         execDisable,
  output logic              regReq,
  output mbr_reg_req_t      regCmd,
  input  wire logic         regAck,
  input  wire logic [15:0]  regRdata,
  input  wire logic         regRangeErr,
  output logic              txValid,
  input  wire logic         txReady,
  output logic [7:0]        txData,
  output logic              busy,
  output logic [7:0]        lastErrCode
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  localparam int IW = $clog2(MAX_REGS);

  generate
    if (MAX_REGS < 2 || MAX_REGS > 16 || (1 << IW) != MAX_REGS) begin : g_bad
      $error("mbr_request_checker: MAX_REGS must be 2, 4, 8 or 16");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  mbr_state_t  state;
  logic [7:0]  qBuf [QUERY_MAX];
  logic [8:0]  qLen;
  logic        qErr;
  logic [15:0] rxCrc;
  logic [7:0]  excCode;
  logic [IW-1:0] idx;
  logic [15:0] rdBuf [MAX_REGS];
  logic [5:0]  txIdx;
  logic [15:0] txCrc;

  // ----------------------------------------
  // Query fields
  // ----------------------------------------
  wire [7:0]  fc     = qBuf[1];
  wire [15:0] addr   = {qBuf[2], qBuf[3]};
  wire [15:0] cnt    = {qBuf[4], qBuf[5]};
  wire        isRd   = (fc == FC_READ);
  wire        isWs   = (fc == FC_WRITE1);
  wire        isDg   = (fc == FC_DIAG);
  wire        isWm   = (fc == FC_WRITEN);
  wire        isWr   = isWs || isWm;
  wire        bcast  = (qBuf[0] == BCAST_ADDR);
  wire [15:0] nRegs  = isWs ? 16'h0001 : cnt;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  wire fcBad   = !(isRd || isWr || isDg);
  wire subBad  = isDg && (addr != 16'h0000);
  wire addrBad = !isDg && (addr > ADDR_MAX);
  wire endBad  = !isDg && (({1'b0, addr} + {1'b0, nRegs}) >= ADDR_END);
  wire cntBad  = (isRd || isWm) &&
                 ((cnt == 16'h0000) || (cnt > CNT_LIMIT)
                  || (cnt > 16'(MAX_REGS)));
  wire bcBad   = isWm && (qBuf[6] != {cnt[6:0], 1'b0});
  wire lenBad  = isWm ? (qLen != WM_HDR_LEN + {1'b0, qBuf[6]})
                      : (qLen != FIXED_LEN);
  wire nvmBusy = internal_processing_busy_flag || nvmAlarm;
  wire disBad  = isWr && execDisable;

  // Only the first failing cause is reported
  wire [7:0] chkExc = (fcBad || subBad)            ? EXC_FUNC :
                      (addrBad || endBad)          ? EXC_ADDR :
                      (cntBad || bcBad || lenBad)  ? EXC_DATA :
                      (toolSession || nvmBusy || disBad) ? EXC_BUSY :
                      EXC_NONE;
  wire [7:0] chkErr = (fcBad || subBad)  ? ERR_NONE :
                      (addrBad || endBad) ? ERR_ADDR :
                      cntBad             ? ERR_RANGE :
                      (bcBad || lenBad)  ? ERR_NONE :
                      toolSession        ? ERR_TOOL :
                      nvmBusy            ? ERR_NVM :
                      disBad             ? ERR_DISABLE :
                      ERR_NONE;

  // Valid CRC leaves a zero remainder over the whole frame
  wire frameOk = !qErr && (rxCrc == 16'h0000) &&
                 (qLen >= MIN_FRAME) && (qLen <= MAX_FRAME) &&
                 (bcast || (qBuf[0] == slaveAddr));

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  wire [5:0]  wPos    = WM_DATA + 6'({idx, 1'b0});
  wire [15:0] wData   = isWs ? cnt : {qBuf[wPos], qBuf[wPos + 6'h01]};
  wire        lastReg = ((16'(idx) + 16'h0001) == nRegs);
  wire        accDone = (state == S_ACC) && regAck;
  wire        rangeHit = accDone && isWr && regRangeErr;

  assign regReq       = (state == S_ACC);
  // Consecutive registers go in ascending address order, starting at the query address
  assign regCmd.addr  = addr + 16'(idx);
  assign regCmd.write = isWr;
  assign regCmd.wdata = wData;

  // ----------------------------------------
  // Response builder
  // ----------------------------------------
  wire        isExc   = (excCode != EXC_NONE);
  wire [5:0]  respLen = isExc ? EXC_LEN :
                        isRd  ? READ_HDR + 6'({cnt[4:0], 1'b0}) : ECHO_LEN;
  wire [5:0]  rdOff   = txIdx - READ_HDR;
  wire [15:0] rdWord  = rdBuf[rdOff[IW:1]];
  wire [7:0]  rdByte  = rdOff[0] ? rdWord[7:0] : rdWord[15:8];
  wire [7:0]  bodyByte =
      (txIdx == 6'h00) ? qBuf[0] :
      (txIdx == 6'h01) ? (isExc ? (fc | EXC_FLAG) : fc) :
      isExc            ? excCode :
      !isRd            ? qBuf[txIdx] :
      (txIdx == READ_HDR - 6'h01) ? {cnt[6:0], 1'b0} :
      rdByte;
  wire        inBody  = (txIdx < respLen);
  wire [7:0]  pushByte = inBody ? bodyByte :
                         (txIdx == respLen) ? txCrc[7:0] : txCrc[15:8];
  wire        fifoReady;
  wire        push    = ce && (state == S_RESP);
  wire        pushed  = push && fifoReady;
  wire        lastByte = (txIdx == respLen + 6'h01);

  // ----------------------------------------
  // Next-state selection
  // ----------------------------------------
  mbr_state_t next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      S_RX: begin
        if (rxEnd) begin
          next_state = frameOk ? S_CHECK : S_RX;
        end
      end
      S_CHECK: begin
        if (chkExc != EXC_NONE) begin
          next_state = bcast ? S_RX : S_RESP;
        end else begin
          next_state = isDg ? (bcast ? S_RX : S_RESP) : S_ACC;
        end
      end
      S_ACC: begin
        if (rangeHit || (regAck && lastReg)) begin
          next_state = bcast ? S_RX : S_RESP;
        end
      end
      S_RESP: begin
        if (pushed && lastByte) begin
          next_state = S_RX;
        end
      end
      default: next_state = S_RX;
    endcase
  end

  // ----------------------------------------
  // Query capture
  // ----------------------------------------
  wire rxTake  = (state == S_RX) && rxValid;
  // Accepted frames keep their length into S_CHECK, cleared one cycle later
  wire rxClear = ((state == S_RX) && rxEnd && !frameOk) || (state == S_CHECK);

  always_ff @(posedge mclk) begin
    if (ce && rxTake && (qLen < 9'(QUERY_MAX))) begin
      qBuf[qLen[5:0]] <= rxData;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      qLen  <= '0;
      qErr  <= 1'b0;
      rxCrc <= CRC_INIT;
    end else if (ce) begin
      if (rxClear) begin
        qLen  <= '0;
        qErr  <= 1'b0;
        rxCrc <= CRC_INIT;
      end else if (rxTake) begin
        qLen  <= (qLen == LEN_SAT) ? qLen : qLen + 9'h001;
        qErr  <= qErr || rxErr;
        rxCrc <= mbr_crc_byte(rxCrc, rxData);
      end
    end
  end

  // ----------------------------------------
  // Read data store
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (ce && accDone && !isWr) begin
      rdBuf[idx] <= regRdata;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= S_RX;
      excCode     <= EXC_NONE;
      lastErrCode <= ERR_NONE;
      idx         <= '0;
      txIdx       <= '0;
      txCrc       <= CRC_INIT;
    end else if (ce) begin
      state <= next_state;
      if (state == S_CHECK) begin
        excCode <= chkExc;
        idx     <= '0;
        txIdx   <= '0;
        txCrc   <= CRC_INIT;
        if (chkErr != ERR_NONE) begin
          lastErrCode <= chkErr;
        end
      end
      if (rangeHit) begin
        excCode     <= EXC_BUSY;
        lastErrCode <= ERR_RANGE;
      end else if (accDone && !lastReg) begin
        idx <= idx + 1'b1;
      end
      if (pushed) begin
        txIdx <= txIdx + 6'h01;
        if (inBody) begin
          txCrc <= mbr_crc_byte(txCrc, pushByte);
        end
      end
    end
  end

  assign busy = (state != S_RX);

  // ----------------------------------------
  // Response FIFO
  // ----------------------------------------
  // Transmitter back-pressure stalls the builder, never drops bytes
  mbr_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .ce       (ce),
    .inValid  (push),
    .inReady  (fifoReady),
    .inData   (pushByte),
    .outValid (txValid),
    .outReady (txReady),
    .outData  (txData)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_func_reject : assert property (ce && state == S_CHECK && fcBad
    |=> excCode == EXC_FUNC)
    else $error("unknown function not rejected with 01h");

  a_addr_reject : assert property (ce && state == S_CHECK && !fcBad
    && !subBad && addrBad |=> excCode == EXC_ADDR && lastErrCode == ERR_ADDR)
    else $error("bad address not rejected with 02h/88h");

  a_end_reject : assert property (ce && state == S_CHECK && !fcBad
    && !subBad && endBad |=> excCode == EXC_ADDR)
    else $error("address plus count overflow not rejected");

  a_count_reject : assert property (ce && state == S_CHECK && !fcBad
    && !subBad && !addrBad && !endBad && cntBad
    |=> excCode == EXC_DATA && lastErrCode == ERR_RANGE)
    else $error("bad count not rejected with 03h/8Ch");

  a_tool_busy : assert property (ce && state == S_CHECK
    && chkExc == EXC_BUSY && toolSession |=> lastErrCode == ERR_TOOL)
    else $error("tool session not reported as 89h");

  a_bad_drop : assert property (ce && state == S_RX && rxEnd
    && !frameOk |=> state == S_RX [*2])
    else $error("discarded query left receive state");

  a_addr_ascend : assert property (ce && accDone && !lastReg
    && !rangeHit ##1 ce |-> regCmd.addr == $past(regCmd.addr) + 16'h0001)
    else $error("register address did not step up by one");

  a_exc_flag : assert property (push && txIdx == 6'h01 && isExc
    |-> pushByte == (fc | EXC_FLAG))
    else $error("exception function code lacks 80h");

  a_bcast_quiet : assert property (push |-> !bcast)
    else $error("response queued for broadcast");

  a_crc_start : assert property (ce && state == S_CHECK
    |=> txCrc == CRC_INIT && txIdx == 6'h00)
    else $error("transmit CRC not seeded");

endmodule : mbr_request_checker

// File: bench/mbr_reg_store.sv
/*
  Parameter store model facing the register port of the request checker.
  Assumes mclk only; slow adds three wait states, badRange flags writes with a range error but still records them in lastWr.
*/
`timescale 1ns/100ps
module mbr_reg_store
  import mbr_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         slow,
  input  wire logic         badRange,
  input  wire logic         regReq,
  input  wire mbr_reg_req_t regCmd,
  output logic              regAck,
  output logic [15:0]       regRdata,
  output logic              regRangeErr,
  output logic [31:0]       lastWr
);
  // ------
  // Ack timing
  // ------
  logic [1:0] waitCnt;
  wire        fire = regReq && !regAck && (waitCnt == (slow ? 2'h3 : 2'h0));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      regAck      <= 1'b0;
      regRdata    <= 16'h0000;
      regRangeErr <= 1'b0;
      waitCnt     <= 2'h0;
      lastWr      <= 32'h0;
    end else begin
      regAck      <= fire;
      regRangeErr <= fire && regCmd.write && badRange;
      waitCnt     <= (regReq && !fire && !regAck) ? waitCnt + 2'h1 : 2'h0;
      // Stale data toggles so a late sample cannot pass
      regRdata    <= fire ? (regCmd.addr ^ 16'hC35A) : ~regRdata;
      if (fire && regCmd.write) lastWr <= {regCmd.addr, regCmd.wdata};
    end
  end
endmodule : mbr_reg_store

// File: bench/tb_modbus_rtu_slave_request_checker.sv
/*
  Self-checking bench for the request checker: queries in, responses out.
  Assumes mbr_pkg, the design and the store model are compiled first.
*/
`timescale 1ns/100ps
module tb_modbus_rtu_slave_request_checker
  import mbr_pkg::*;
;
  typedef logic [7:0] mbr_bytes_t[$];
  logic         mclk = 0, reset_n = 0, slow = 0;
  logic         rxValid = 0, rxErr = 0, rxEnd = 0, txReady = 1;
  logic [7:0]   rxData = 8'h00;
  logic [4:0]   lv = 5'h00; // Tool, busy flag, alarm, disable, bad range
  logic         regReq, regAck, regRangeErr, txValid, busy;
  logic [15:0]  regRdata;
  logic [31:0]  lastWr;
  logic [7:0]   txData, lastErrCode;
  mbr_reg_req_t regCmd;
  int           errors = 0;
  int           comparisons = 0;

  mbr_request_checker #(.MAX_REGS(16), .FIFO_DEPTH(16)) DUT (
    .mclk(mclk), .reset_n(reset_n), .ce(1'b1), .slaveAddr(8'h01),
    .rxValid(rxValid), .rxData(rxData), .rxErr(rxErr), .rxEnd(rxEnd),
    .toolSession(lv[4]), .internal_processing_busy_flag(lv[3]),
    .nvmAlarm(lv[2]), .execDisable(lv[1]), .regReq(regReq), .regCmd(regCmd),
    .regAck(regAck), .regRdata(regRdata), .regRangeErr(regRangeErr),
    .txValid(txValid), .txReady(txReady), .txData(txData), .busy(busy),
    .lastErrCode(lastErrCode));
  mbr_reg_store PS (
    .mclk(mclk), .reset_n(reset_n), .slow(slow), .badRange(lv[0]),
    .regReq(regReq), .regCmd(regCmd), .regAck(regAck), .regRdata(regRdata),
    .regRangeErr(regRangeErr), .lastWr(lastWr));

  initial forever #12.5 mclk = ~mclk;

  // ------
  // Shared helpers
  // ------
  task automatic print_verdict;
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cmpq(input mbr_bytes_t got, input mbr_bytes_t exp);
    check(got.size(), exp.size());
    foreach (exp[i]) if (i < got.size()) check(got[i], exp[i]);
  endtask : cmpq

  function automatic mbr_bytes_t withCrc(input mbr_bytes_t q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return {q, c[7:0], c[15:8]};
  endfunction : withCrc

  // Mode 1 spoils the CRC, mode 2 flags a byte error
  task automatic query(input mbr_bytes_t q, input int mode, input int stall,
                       output mbr_bytes_t got, output bit sawBusy);
    mbr_bytes_t f;
    int         idle;
    f = withCrc(q);
    if (mode == 1) f[f.size()-1] ^= 8'h01;
    txReady <= (stall == 0);
    foreach (f[i]) begin
      @(posedge mclk);
      rxValid <= 1'b1;
      rxData  <= f[i];
      rxErr   <= (mode == 2 && i == 2);
    end
    @(posedge mclk);
    rxValid <= 1'b0;
    rxErr   <= 1'b0;
    @(posedge mclk);
    rxEnd <= 1'b1;
    @(posedge mclk);
    rxEnd   <= 1'b0;
    got     = {};
    sawBusy = 0;
    idle    = 0;
    for (int c = 0; c < 700 && idle < 30; c++) begin
      @(posedge mclk);
      if (busy === 1'b1) sawBusy = 1;
      if (txValid === 1'b1 && txReady === 1'b1) got.push_back(txData);
      idle = (txValid === 1'b1 || busy === 1'b1) ? 0 : idle + 1;
      // Full buffer must hold the builder back, not drop bytes
      if (stall > 0 && c == stall) check({busy, txValid}, 2'h3);
      txReady <= (c >= stall);
    end
  endtask : query

  task automatic doRead(input logic [15:0] a, input logic [7:0] n, input int stall);
    mbr_bytes_t got, exp;
    bit         b;
    logic [15:0] v;
    query({8'h01, 8'h03, a[15:8], a[7:0], 8'h00, n}, 0, stall, got, b);
    exp = {8'h01, 8'h03, 8'(2 * n)};
    for (int i = 0; i < n; i++) begin
      v = (a + 16'(i)) ^ 16'hC35A;
      exp.push_back(v[15:8]);
      exp.push_back(v[7:0]);
    end
    cmpq(got, withCrc(exp));
  endtask : doRead

  task automatic exc(input mbr_bytes_t q, input logic [4:0] l, input logic [7:0] code,
                     input logic [7:0] err);
    mbr_bytes_t got;
    bit         b;
    lv <= l;
    query(q, 0, 0, got, b);
    lv <= 5'h00;
    cmpq(got, withCrc({q[0], q[1] | 8'h80, code}));
    if (err != 8'h00) check(lastErrCode, err);
  endtask : exc

  // ------
  // Scenarios
  // ------
  task automatic t_read;
    doRead(16'h0402, 8'h04, 0);
    slow <= 1'b1;
    doRead(16'h1FEF, 8'h10, 150);
    slow <= 1'b0;
  endtask : t_read

  task automatic t_exc;
    exc({8'h01, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, 5'h10, 8'h01, 8'h00);
    exc({8'h01, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34}, 5'h00, 8'h01, 8'h00);
    exc({8'h01, 8'h03, 8'h20, 8'h00, 8'h00, 8'h00}, 5'h00, 8'h02, 8'h88);
    exc({8'h01, 8'h03, 8'h1F, 8'hF0, 8'h00, 8'h10}, 5'h00, 8'h02, 8'h88);
    exc({8'h01, 8'h03, 8'h04, 8'h02, 8'h00, 8'h00}, 5'h10, 8'h03, 8'h8C);
    exc({8'h01, 8'h03, 8'h04, 8'h02, 8'h00, 8'h11}, 5'h00, 8'h03, 8'h8C);
    exc({8'h01, 8'h10, 8'h02, 8'h42, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00, 8'h03,
         8'h20}, 5'h00, 8'h03, 8'h00);
    exc({8'h01, 8'h03, 8'h04, 8'h02, 8'h00, 8'h01, 8'h00}, 5'h00, 8'h03, 8'h00);
    exc({8'h01, 8'h03, 8'h04, 8'h02, 8'h00, 8'h01}, 5'h18, 8'h04, 8'h89);
    exc({8'h01, 8'h03, 8'h04, 8'h02, 8'h00, 8'h01}, 5'h08, 8'h04, 8'h8A);
    exc({8'h01, 8'h03, 8'h04, 8'h02, 8'h00, 8'h01}, 5'h04, 8'h04, 8'h8A);
    exc({8'h01, 8'h06, 8'h02, 8'h4B, 8'h00, 8'h50}, 5'h02, 8'h04, 8'h8D);
    exc({8'h01, 8'h06, 8'h02, 8'h4B, 8'h00, 8'h50}, 5'h01, 8'h04, 8'h8C);
  endtask : t_exc

  task automatic t_drop;
    mbr_bytes_t got, q;
    bit         b;
    q = {8'h01, 8'h03, 8'h04, 8'h02, 8'h00, 8'h01};
    for (int m = 1; m < 3; m++) begin
      query(q, m, 0, got, b);
      check({b, 8'(got.size())}, 9'h000);
    end
    query({8'h05, 8'h03, 8'h04, 8'h02, 8'h00, 8'h01}, 0, 0, got, b);
    check({b, 8'(got.size())}, 9'h000);
    repeat (252) q.push_back(8'h00);
    query(q, 0, 0, got, b);
    check({b, 8'(got.size())}, 9'h000);
    query({8'h00, 8'h06, 8'h02, 8'h4B, 8'h00, 8'h50}, 0, 0, got, b);
    check({b, 8'(got.size())}, 9'h100);
    check(lastWr, 32'h024B0050);
  endtask : t_drop

  task automatic t_write;
    mbr_bytes_t got;
    bit         b;
    query({8'h01, 8'h10, 8'h02, 8'h42, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h03,
           8'h20}, 0, 0, got, b);
    cmpq(got, withCrc({8'h01, 8'h10, 8'h02, 8'h42, 8'h00, 8'h02}));
    check(lastWr, 32'h02430320);
    query({8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 0, 0, got, b);
    cmpq(got, withCrc({8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}));
    query({8'h01, 8'h06, 8'h02, 8'h4C, 8'h00, 8'h51}, 0, 0, got, b);
    cmpq(got, withCrc({8'h01, 8'h06, 8'h02, 8'h4C, 8'h00, 8'h51}));
    check(lastWr, 32'h024C0051);
  endtask : t_write

  // ------
  // Sequence and watchdog
  // ------
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_read();
    t_exc();
    t_drop();
    t_write();
    print_verdict();
  end

  // Whole run needs well under two thousand cycles; this leaves wide margin
  initial begin
    repeat (30000) @(posedge mclk);
    errors++;
    print_verdict();
  end
endmodule : tb_modbus_rtu_slave_request_checker
